// ### design/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
    // Wishbone byte addresses
    localparam logic [3:0] ADR_STAT = 4'h0;
    localparam logic [3:0] ADR_CON1 = 4'h4;
    localparam logic [3:0] ADR_CON2 = 4'h8;
    localparam logic [3:0] ADR_BUF = 4'hc;

    // Status and control fields
    localparam int STAT_EN = 15;
    localparam int STAT_SIDL = 13;
    localparam int STAT_BEC_LO = 8;
    localparam int STAT_ROV = 6;
    localparam int STAT_TBF = 1;
    localparam int STAT_RBF = 0;
    localparam logic [15:0] STAT_RMASK = 16'ha743;

    // Control one fields
    localparam int CON1_CLK_OFF = 12;
    localparam int CON1_SDO_OFF = 11;
    localparam int CON1_WIDE = 10;
    localparam int CON1_SAMP_END = 9;
    localparam int CON1_CKE = 8;
    localparam int CON1_SEL_EN = 7;
    localparam int CON1_IDLE_HI = 6;
    localparam int CON1_MASTER = 5;
    localparam int CON1_SEC_LO = 2;
    localparam int CON1_PRI_LO = 0;
    localparam logic [15:0] CON1_MASK = 16'h1fff;

    // Control two fields
    localparam int CON2_FRMEN = 15;
    localparam int CON2_FSD = 14;
    localparam int CON2_FPOL = 13;
    localparam int CON2_FE = 1;
    localparam int CON2_BEN = 0;
    localparam logic [15:0] CON2_MASK = 16'he003;

    localparam logic [15:0] RST_VAL = 16'h0000;

    // Buffer and word geometry
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam logic [3:0] LIMIT_FIFO = 4'h8;
    localparam logic [3:0] LIMIT_STD = 4'h1;
    localparam logic [5:0] EDGES_WORD = 6'h20;
    localparam logic [5:0] EDGES_BYTE = 6'h10;
    localparam logic [4:0] LAST_BIT_WORD = 5'h0f;
    localparam logic [4:0] LAST_BIT_BYTE = 5'h07;
    localparam logic [3:0] SEC_BASE = 4'h8;

    typedef enum logic [1:0] {
        SFP_IDLE = 2'b00,
        SFP_PRE = 2'b01,
        SFP_SHIFT = 2'b10
    } sfp_mstate_e;

    typedef struct packed {
        logic sck_i;
        logic sdi_i;
        logic ss_i;
    } sfp_pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic ss_o;
        logic ss_oe;
    } sfp_pin_out_s;
endpackage : sfp_pkg
`default_nettype wire

// ### design/sfp_fifo.sv
`default_nettype none
module sfp_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic flush,
    input wire logic [3:0] limit,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [sfp_pkg::WORD_W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [sfp_pkg::WORD_W-1:0] out_data,
    output logic [3:0] count
);
    import sfp_pkg::*;

    logic [WORD_W-1:0] mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] wp_r;
    logic [PTR_W-1:0] rp_r;
    logic [3:0] cnt_r;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Limit of one gives the single holding buffer
    assign in_ready = cnt_r < limit;
    assign out_valid = cnt_r != 4'h0;
    assign out_data = mem_r[rp_r];
    assign count = cnt_r;

    genvar i;
    for (i = 0; i < FIFO_DEPTH; i++) begin : g_ent
        always_ff @(posedge clk) begin
            if (push && wp_r == PTR_W'(i)) begin
                mem_r[i] <= in_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= 4'h0;
        end else begin
            wp_r <= wp_r + PTR_W'(push);
            rp_r <= rp_r + PTR_W'(pop);
            cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
        end
    end
endmodule : sfp_fifo
`default_nettype wire

// ### design/sfp_port.sv
`default_nettype none
module sfp_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core power state
    input wire logic cpu_idle,
    // Serial pins
    input wire sfp_pkg::sfp_pin_in_s pin_i,
    output sfp_pkg::sfp_pin_out_s pin_o
);
    import sfp_pkg::*;

    logic en_r;
    logic sidl_r;
    logic rov_r;
    logic [15:0] con1_r;
    logic [15:0] con2_r;
    logic ack_r;
    logic [31:0] rdat_r;
    sfp_mstate_e mstate_r;
    logic [9:0] div_r;
    logic [5:0] edge_r;
    logic sck_r;
    logic fs_r;
    logic [15:0] tx_sr_r;
    logic [15:0] rx_sr_r;
    logic sck_prev_r;
    logic [4:0] scnt_r;
    logic sr_valid_r;
    logic armed_r;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    // Write lands on the ack edge, where the master samples it
    wire wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i;
    wire rd = req & ~wb_we_i;
    wire sel_stat = wb_adr_i == ADR_STAT;
    wire sel_con1 = wb_adr_i == ADR_CON1;
    wire sel_con2 = wb_adr_i == ADR_CON2;
    wire sel_buf = wb_adr_i == ADR_BUF;
    wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0] wdat = wb_dat_i[15:0];

    // Configuration fields
    wire clk_off = con1_r[CON1_CLK_OFF];
    wire sdo_off = con1_r[CON1_SDO_OFF];
    wire wide = con1_r[CON1_WIDE];
    wire samp_end = con1_r[CON1_SAMP_END];
    wire cke = con1_r[CON1_CKE];
    wire sel_en = con1_r[CON1_SEL_EN];
    wire idle_hi = con1_r[CON1_IDLE_HI];
    wire mst = con1_r[CON1_MASTER];
    wire frmen = con2_r[CON2_FRMEN];
    wire fsd = con2_r[CON2_FSD];
    wire fpol = con2_r[CON2_FPOL];
    wire fe = con2_r[CON2_FE];
    wire ben = con2_r[CON2_BEN];

    wire halt = sidl_r & cpu_idle;
    wire run = en_r & ~halt;
    wire [5:0] nedge = wide ? EDGES_WORD : EDGES_BYTE;
    wire [4:0] last_bit = wide ? LAST_BIT_WORD : LAST_BIT_BYTE;

    // Buffers
    wire [3:0] limit = ben ? LIMIT_FIFO : LIMIT_STD;
    wire tx_in_valid = wr & sel_buf & (|wb_sel_i[1:0]);
    wire tx_in_ready;
    wire tx_out_valid;
    wire [15:0] tx_out_data;
    wire [3:0] tx_cnt;
    wire rx_in_ready;
    wire rx_out_valid;
    wire rx_out_ready = rd & sel_buf;
    wire [15:0] rx_out_data;
    wire [3:0] rx_cnt;

    // Prescaler and shift clock divider
    wire [1:0] pri_sel = con1_r[CON1_PRI_LO +: 2];
    wire [2:0] sec_sel = con1_r[CON1_SEC_LO +: 3];
    wire [6:0] prim_div = 7'h01 << {~pri_sel, 1'b0};
    wire [3:0] sec_div = SEC_BASE - {1'b0, sec_sel};
    wire [9:0] ratio = {3'h0, prim_div} * {6'h00, sec_div};
    wire [9:0] half_lo = ratio >> 1;
    wire [9:0] half_a = (half_lo == 10'h000) ? 10'h001 : half_lo;
    wire [9:0] half_b = ratio - half_lo;
    wire [9:0] cur_half = edge_r[0] ? half_b : half_a;
    // Ratio one cannot toggle twice per clock, so it runs at half rate
    wire tick = ~halt & ((div_r + 10'h001) >= cur_half);

    // Master engine decode
    wire fs_in_act = pin_i.ss_i == fpol;
    wire m_on = en_r & mst;
    wire m_start = m_on & ~halt & (mstate_r == SFP_IDLE) & tx_out_valid
        & (~(frmen & fsd) | fs_in_act);
    wire m_shifting = m_on & (mstate_r == SFP_SHIFT) & tick;
    wire m_end = m_shifting & (edge_r == nedge);
    wire m_edge = m_shifting & (edge_r != nedge);
    wire is_chg = cke ? edge_r[0] : ~edge_r[0];
    wire chg_nz = is_chg & (edge_r != 6'h00);
    wire m_shift = m_edge & chg_nz;
    wire m_samp = m_edge & (samp_end ? chg_nz : ~is_chg);
    wire m_end_samp = m_end & samp_end & ~cke;

    // Slave engine decode
    wire s_on = en_r & ~mst;
    wire s_act = s_on & ~halt;
    wire s_rise = pin_i.sck_i & ~sck_prev_r;
    wire s_fall = ~pin_i.sck_i & sck_prev_r;
    wire s_lead = idle_hi ? s_fall : s_rise;
    wire s_trail = idle_hi ? s_rise : s_fall;
    wire s_go = frmen ? (~fsd | armed_r | fs_in_act) : (~sel_en | ~pin_i.ss_i);
    wire s_chg = s_act & s_go & (cke ? s_trail : s_lead) & (scnt_r != 5'h00);
    wire s_samp = s_act & s_go & (cke ? s_lead : s_trail);
    wire s_end = s_samp & (scnt_r == last_bit);
    wire s_load = s_act & ~sr_valid_r & tx_out_valid & (scnt_r == 5'h00);
    wire s_fs = sr_valid_r & (scnt_r == 5'h00);

    // Word completion
    wire tx_pop = m_start | s_load;
    wire word_done = m_end | s_end;
    wire [15:0] rx_shift = {rx_sr_r[14:0], pin_i.sdi_i};
    wire [15:0] rx_word = (m_end_samp | s_end) ? rx_shift : rx_sr_r;
    wire [15:0] rx_push_data = wide ? rx_word : {8'h00, rx_word[7:0]};
    wire rx_in_valid = word_done & rx_in_ready;
    wire rov_set = word_done & ~rx_in_ready;
    wire [15:0] load_word = wide ? tx_out_data : {tx_out_data[7:0], 8'h00};

    // Status readback
    wire tbf = ~tx_in_ready;
    wire rbf = ~rx_in_ready;
    wire [3:0] bec_src = mst ? tx_cnt : rx_cnt;
    wire [2:0] bec = bec_src[3] ? 3'h7 : bec_src[2:0];
    wire [15:0] stat_rd = {en_r, 1'b0, sidl_r, 2'b00, bec, 1'b0, rov_r, 4'h0, tbf, rbf};
    wire [15:0] rd_mux = sel_stat ? stat_rd :
        sel_con1 ? con1_r :
        sel_con2 ? con2_r :
        sel_buf ? rx_out_data : 16'h0000;

    sfp_fifo u_tx_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .flush(~en_r),
        .limit(limit),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .in_data(wdat),
        .out_valid(tx_out_valid),
        .out_ready(tx_pop),
        .out_data(tx_out_data),
        .count(tx_cnt)
    );

    sfp_fifo u_rx_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .flush(~en_r),
        .limit(limit),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .in_data(rx_push_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_data),
        .count(rx_cnt)
    );

    // Registers and bus answer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_r <= 1'b0;
            sidl_r <= 1'b0;
            rov_r <= 1'b0;
            con1_r <= RST_VAL;
            con2_r <= RST_VAL;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (rd) begin
                rdat_r <= {16'h0000, rd_mux};
            end
            if (wr && sel_stat && wb_sel_i[1]) begin
                en_r <= wdat[STAT_EN];
                sidl_r <= wdat[STAT_SIDL];
            end
            if (wr && sel_con1) begin
                con1_r <= ((con1_r & ~wmask) | (wdat & wmask)) & CON1_MASK;
            end
            if (wr && sel_con2) begin
                con2_r <= ((con2_r & ~wmask) | (wdat & wmask)) & CON2_MASK;
            end
            // Set wins over a clearing write in the same cycle
            if (rov_set) begin
                rov_r <= 1'b1;
            end else if (wr && sel_stat && wb_sel_i[0] && !wdat[STAT_ROV]) begin
                rov_r <= 1'b0;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Master clock and frame sequencing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mstate_r <= SFP_IDLE;
            div_r <= 10'h000;
            edge_r <= 6'h00;
            sck_r <= 1'b0;
            fs_r <= 1'b0;
        end else if (!m_on) begin
            mstate_r <= SFP_IDLE;
            div_r <= 10'h000;
            edge_r <= 6'h00;
            sck_r <= idle_hi;
            fs_r <= 1'b0;
        end else if (m_start) begin
            mstate_r <= (frmen & ~fsd & ~fe) ? SFP_PRE : SFP_SHIFT;
            div_r <= 10'h000;
            edge_r <= 6'h00;
            fs_r <= frmen & ~fsd;
        end else if (mstate_r == SFP_IDLE) begin
            sck_r <= idle_hi;
        end else if (mstate_r == SFP_PRE && tick) begin
            // Sync pulse fills one bit time ahead of the first edge
            div_r <= 10'h000;
            edge_r <= edge_r[0] ? 6'h00 : 6'h01;
            if (edge_r[0]) begin
                mstate_r <= SFP_SHIFT;
                fs_r <= 1'b0;
            end
        end else if (m_edge) begin
            div_r <= 10'h000;
            edge_r <= edge_r + 6'h01;
            sck_r <= ~sck_r;
            if (edge_r == 6'h01) begin
                fs_r <= 1'b0;
            end
        end else if (m_end) begin
            mstate_r <= SFP_IDLE;
            div_r <= 10'h000;
            edge_r <= 6'h00;
        end else if (!halt) begin
            div_r <= div_r + 10'h001;
        end
    end

    // Shared shift registers, data leaves msb first
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_sr_r <= 16'h0000;
            rx_sr_r <= 16'h0000;
        end else begin
            if (tx_pop) begin
                tx_sr_r <= load_word;
            end else if (m_shift || s_chg) begin
                tx_sr_r <= {tx_sr_r[14:0], 1'b0};
            end
            if (m_samp || s_samp) begin
                rx_sr_r <= rx_shift;
            end
        end
    end

    // Slave bit counting and frame arming
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sck_prev_r <= 1'b0;
            scnt_r <= 5'h00;
            sr_valid_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            sck_prev_r <= pin_i.sck_i;
            if (!s_on) begin
                scnt_r <= 5'h00;
                sr_valid_r <= 1'b0;
                armed_r <= 1'b0;
            end else begin
                if (s_end) begin
                    scnt_r <= 5'h00;
                end else if (s_samp) begin
                    scnt_r <= scnt_r + 5'h01;
                end else if (!s_go) begin
                    scnt_r <= 5'h00;
                end
                if (s_load) begin
                    sr_valid_r <= 1'b1;
                end else if (s_end) begin
                    sr_valid_r <= 1'b0;
                end
                if (s_end) begin
                    armed_r <= 1'b0;
                end else if (frmen && fsd && fs_in_act) begin
                    armed_r <= 1'b1;
                end
            end
        end
    end

    // Pin drive
    wire fs_act = mst ? fs_r : s_fs;
    assign pin_o.sck_o = sck_r;
    assign pin_o.sck_oe = en_r & mst & ~clk_off;
    assign pin_o.sdo_o = tx_sr_r[15];
    assign pin_o.sdo_oe = en_r & ~sdo_off & (mst | frmen | ~sel_en | ~pin_i.ss_i);
    assign pin_o.ss_o = fpol ? fs_act : ~fs_act;
    assign pin_o.ss_oe = en_r & frmen & ~fsd;

    default clocking a_clk @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_tbf_on_write:
    assert property ((en_r && tx_in_valid && tx_in_ready && !ben && !tx_pop) |=> tbf)
        else $error("transmit full not set by write");
    a_tbf_on_move:
    assert property ((tx_pop && !ben && en_r) |=> !tbf)
        else $error("transmit full not cleared by move");
    a_tbf_fifo:
    assert property ((ben && tx_cnt == 4'h7 && tx_in_valid && !tx_pop && en_r) |=> tbf ##1 tbf
        or tx_pop) else $error("fifo transmit full wrong");
    a_rbf_on_read:
    assert property ((rx_out_ready && rx_out_valid && !ben && !rx_in_valid) |=> !rbf)
        else $error("receive full not cleared by read");
    a_rov_discard:
    assert property ((word_done && rbf && !rx_out_ready) |=> rov_r && $stable(rx_cnt))
        else $error("overflow word not discarded");
    a_write_starts:
    assert property ((m_on && !halt && mstate_r == SFP_IDLE && !tx_out_valid && tx_in_valid
        && !frmen && !cpu_idle) |-> ##2 (mstate_r != SFP_IDLE))
        else $error("master did not start after write");
    a_idle_freeze:
    assert property ((halt && mstate_r == SFP_SHIFT && !wr) |=> $stable(edge_r) && $stable(sck_r))
        else $error("shifting continued while halted");
    a_pins_off:
    assert property (!en_r |-> !(pin_o.sck_oe || pin_o.sdo_oe || pin_o.ss_oe))
        else $error("pin driven while disabled");
    a_sck_idle:
    assert property ((m_on && mstate_r == SFP_IDLE && $stable(idle_hi))[*2]
        |-> pin_o.sck_o == idle_hi)
        else $error("idle clock level wrong");
    a_rsvd_zero:
    assert property ((ack_r && !wb_we_i && wb_adr_i == ADR_STAT) |-> (wb_dat_o[15:0] & ~STAT_RMASK)
        == 16'h0000) else $error("reserved status bit nonzero");
    a_depth_cap:
    assert property (tx_cnt <= limit && rx_cnt <= limit)
        else $error("buffer above selected depth");
endmodule : sfp_port
`default_nettype wire

// ### tb/sfp_spi_peer.sv
`default_nettype none
module sfp_spi_peer (
    // Clock
    input wire logic ref_clk,
    // Serial pins
    input wire logic sck,
    input wire logic sdo,
    output logic sdi,
    // Bench side
    input wire logic frame,
    input wire logic [15:0] reply,
    output logic [15:0] got,
    output int edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_q = 1'b0;
    logic last = 1'b0;
    logic [15:0] tx = 16'h0000;
    initial got = 16'h0000;
    initial edges = 0;
    // Outside a frame the line shows no stale bit
    assign sdi = frame ? tx[15] : ~last;
    always @(posedge ref_clk) begin
        sck_q <= sck;
        last <= sdi;
        if (!frame) begin
            tx <= reply;
            edges <= 0;
        end else if (sck != sck_q) begin
            edges <= edges + 1;
            if (sck) begin
                got <= {got[14:0], sdo};
            end else begin
                tx <= {tx[14:0], 1'b0};
            end
        end
    end
endmodule : sfp_spi_peer
`default_nettype wire

// ### tb/sfp_port_tb.sv
`default_nettype none
module sfp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sfp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic cpu_idle = 1'b0;
    logic sdi;
    logic frame = 1'b0;
    logic s_sck = 1'b0;
    logic s_ss = 1'b1;
    logic [15:0] reply = 16'h0000;
    logic [15:0] got;
    int edges;
    sfp_pin_in_s pin_i;
    sfp_pin_out_s pin_o;
    int error_cnt = 0;
    int n_checks = 0;
    assign pin_i = {s_sck, sdi, s_ss};
    always #20 ref_clk = ~ref_clk;
    sfp_port sfp_port_inst (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_idle(cpu_idle),
        .pin_i(pin_i), .pin_o(pin_o));
    // Peer follows the bench clock while the port is a slave
    sfp_spi_peer sfp_spi_peer_inst (.ref_clk(ref_clk),
        .sck(pin_o.sck_oe ? pin_o.sck_o : s_sck),
        .sdo(pin_o.sdo_o), .sdi(sdi), .frame(frame), .reply(reply), .got(got),
        .edges(edges));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Entered and left just after a rising edge
    task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [15:0] d,
            output logic [15:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            error_cnt++;
        q = rdat[15:0];
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask : wb_xfer
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] q;
        wb_xfer(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask : rd_chk
    task automatic wait_bit(input int b);
        logic [15:0] q;
        int n;
        n = 0;
        do begin
            wb_xfer(1'b0, ADR_STAT, 16'h0000, q);
            n++;
        end while (q[b] !== 1'b1 && n < 500);
        if (n >= 500)
            error_cnt++;
    endtask : wait_bit
    task automatic t_regs;
        rd_chk(ADR_STAT, 16'h0000);
        rd_chk(ADR_CON1, 16'h0000);
        chk({10'h000, pin_o.sck_oe, pin_o.sdo_oe, 4'h0}, 16'h0000);
        wr(ADR_CON1, 16'hffff);
        rd_chk(ADR_CON1, 16'h1fff);
        wr(ADR_CON2, 16'hffff);
        rd_chk(ADR_CON2, 16'he003);
        wr(ADR_STAT, 16'h7fbf);
        rd_chk(ADR_STAT, 16'h2000);
        rd_chk(4'h2, 16'h0000);
        wr(ADR_STAT, 16'h0000);
        wr(ADR_CON2, 16'h0000);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_pins;
        // Both pins released to general use
        wr(ADR_CON1, 16'h1860);
        wr(ADR_STAT, 16'h8000);
        chk({14'h0000, pin_o.sck_oe, pin_o.sdo_oe}, 16'h0000);
        wr(ADR_CON1, 16'h0060);
        chk({14'h0000, pin_o.sck_oe, pin_o.sck_o}, 16'h0003);
        wr(ADR_STAT, 16'h0000);
        $display("t_pins done");
    endtask : t_pins
    task automatic t_master8;
        // Ratio 4, so the peer has time to shift between edges
        reply <= 16'h5a00;
        wr(ADR_CON1, 16'h013e);
        wr(ADR_STAT, 16'h8000);
        chk({15'h0000, pin_o.sdo_oe & pin_o.sck_oe}, 16'h0001);
        frame <= 1'b1;
        wr(ADR_BUF, 16'h00a5);
        wait_bit(STAT_RBF);
        chk(16'(edges), {10'h000, EDGES_BYTE});
        chk({8'h00, got[7:0]}, 16'h00a5);
        rd_chk(ADR_BUF, 16'h005a);
        rd_chk(ADR_STAT, 16'h8000);
        frame <= 1'b0;
        wr(ADR_STAT, 16'h0000);
        $display("t_master8 done");
    endtask : t_master8
    task automatic t_master16;
        int c;
        int e;
        c = 0;
        reply <= 16'hc3e1;
        wr(ADR_CON1, 16'h053a);
        wr(ADR_STAT, 16'ha000);
        frame <= 1'b1;
        wr(ADR_BUF, 16'h9b6d);
        while (pin_o.sck_o !== 1'b1 && c < 100) begin
            @(posedge ref_clk);
            c++;
        end
        c = 0;
        while (pin_o.sck_o === 1'b1 && c < 100) begin
            @(posedge ref_clk);
            c++;
        end
        chk(16'(c), 16'h0004);
        cpu_idle <= 1'b1;
        repeat (2) @(posedge ref_clk);
        e = edges;
        repeat (40) @(posedge ref_clk);
        chk(16'(edges - e), 16'h0000);
        cpu_idle <= 1'b0;
        wait_bit(STAT_RBF);
        chk(16'(edges), {10'h000, EDGES_WORD});
        chk(got, 16'h9b6d);
        rd_chk(ADR_BUF, 16'hc3e1);
        frame <= 1'b0;
        wr(ADR_STAT, 16'h0000);
        $display("t_master16 done");
    endtask : t_master16
    task automatic t_overflow;
        reply <= 16'h3c00;
        wr(ADR_CON1, 16'h013e);
        wr(ADR_STAT, 16'h8000);
        frame <= 1'b1;
        wr(ADR_BUF, 16'h0011);
        wr(ADR_BUF, 16'h0022);
        rd_chk(ADR_STAT, 16'h8102);
        wait_bit(STAT_ROV);
        rd_chk(ADR_STAT, 16'h8041);
        rd_chk(ADR_BUF, 16'h003c);
        wr(ADR_STAT, 16'h8000);
        rd_chk(ADR_STAT, 16'h8000);
        frame <= 1'b0;
        wr(ADR_STAT, 16'h0000);
        $display("t_overflow done");
    endtask : t_overflow
    task automatic t_slave8;
        // Slave, edge and select enable bits set, so the select pin is in use
        reply <= 16'h6900;
        wr(ADR_CON1, 16'h0180);
        wr(ADR_STAT, 16'h8000);
        wr(ADR_BUF, 16'h0096);
        chk({14'h0000, pin_o.ss_oe, pin_o.sdo_oe}, 16'h0000);
        s_ss <= 1'b0;
        frame <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({15'h0000, pin_o.sdo_oe}, 16'h0001);
        repeat (8) begin
            s_sck <= 1'b1;
            repeat (3) @(posedge ref_clk);
            s_sck <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        chk({8'h00, got[7:0]}, 16'h0096);
        rd_chk(ADR_STAT, 16'h8101);
        rd_chk(ADR_BUF, 16'h0069);
        s_ss <= 1'b1;
        frame <= 1'b0;
        wr(ADR_STAT, 16'h0000);
        $display("t_slave8 done");
    endtask : t_slave8
    task automatic t_fifo;
        int i;
        // Slowest ratio keeps the queue from draining
        wr(ADR_CON1, 16'h0120);
        wr(ADR_CON2, 16'h0001);
        wr(ADR_STAT, 16'h8000);
        for (i = 0; i < 8; i++) begin
            wr(ADR_BUF, 16'(i));
        end
        rd_chk(ADR_STAT, 16'h8700);
        wr(ADR_BUF, 16'h0008);
        rd_chk(ADR_STAT, 16'h8702);
        wr(ADR_STAT, 16'h0000);
        rd_chk(ADR_STAT, 16'h0000);
        wr(ADR_CON2, 16'h0000);
        $display("t_fifo done");
    endtask : t_fifo
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_pins();
        t_master8();
        t_master16();
        t_overflow();
        t_slave8();
        t_fifo();
        end_of_test();
    end
endmodule : sfp_port_tb
`default_nettype wire
